// File: shared/cdt_pkg.sv
package cdt_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] CDT_CTRL_OFS = 8'h00;
  localparam logic [7:0] CDT_LOW_CMP_OFS = 8'h04;
  localparam logic [7:0] CDT_HIGH_CMP_OFS = 8'h08;
  localparam logic [7:0] CDT_COUNT_OFS = 8'h0c;
  localparam logic [7:0] CDT_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] CDT_IRQ_MASK_OFS = 8'h14;
  localparam logic [7:0] CDT_PORT_OFS = 8'h18;

  // ==========================================================
  // field positions
  localparam int CDT_COUNT_HIGH_POS = 8;
  localparam int CDT_COUNT_TOG_POS = 16;
  localparam int CDT_IRQ_LOW_MATCH_POS = 0;

  // ==========================================================
  // count clock select codes
  localparam logic [2:0] CDT_SEL_SYS = 3'h0;
  localparam logic [2:0] CDT_SEL_SYS_DIV4 = 3'h1;
  localparam logic [2:0] CDT_SEL_EXT = 3'h2;
  localparam logic [2:0] CDT_SEL_EXT_DIV2 = 3'h3;
  localparam logic [2:0] CDT_SEL_EXT_DIV4 = 3'h4;
  localparam logic [2:0] CDT_SEL_EXT_DIV8 = 3'h5;

  // ==========================================================
  // timing counts
  localparam logic [1:0] CDT_SYS_DIV4_LAST = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] clk_sel;
    logic cascade;
    logic toe;
    logic high_run;
    logic low_run;
  } cdt_ctrl_t;

  typedef struct packed {
    logic out_latch;
    logic event_line_direction;
    logic output_line_direction;
  } cdt_port_t;

  // ==========================================================
  // reset values
  localparam cdt_ctrl_t CDT_CTRL_RST = 7'h00;
  localparam cdt_port_t CDT_PORT_RST = 3'h3;
  localparam logic [7:0] CDT_CMP_RST = 8'h00;
  localparam logic [7:0] CDT_CNT_RST = 8'h00;

endpackage : cdt_pkg

// File: core/cdt_timer.sv
// Notes on behaviour
// R1: event input edges advance the low counter
// R2: 8-bit match clears low counter, raises interrupt
// R3: software stops, routes event pin, then starts
// R4: square-wave match inverts pin, clears, interrupts
// R5: low run enable clear forces output low
// R6: toggle output starts low once enabled
// R7: square period is two times compare plus two
// R8: software prepares pin, compare, then starts
// R9: clock select picks system or event divisions
// R10: cascaded pair forms one 16-bit count
// R11: only low run enable starts cascaded pair
// R12: double match clears both, low interrupt only
// R13: lone low match in cascade does nothing
// R14: 16-bit period is 256X plus N plus one
// R15: software stops both, cascades, starts low only
// R16: software stops timer before changing clock select
// R17: select codes 110 and 111 stop counting
// R18: stopped counters are held at zero
`timescale 1ns/1ns
`default_nettype none

module cdt_timer
  import cdt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic event_pin_i,
  output logic toggle_pin_o,
  output logic toggle_pin_oe_n_o,
  output logic irq_o
);

  // ==========================================================
  // registers
  cdt_ctrl_t ctrl_reg;
  cdt_port_t port_reg;
  logic [7:0] low_compare_reg;
  logic [7:0] high_compare_reg;
  logic [7:0] low_counter_reg;
  logic [7:0] high_counter_reg;
  logic tog_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic ev_s1_reg;
  logic ev_s2_reg;
  logic ev_s3_reg;
  logic [1:0] sys_div_reg;
  logic [2:0] ev_div_reg;

  // ==========================================================
  // bus decode
  logic bus_req;
  logic bus_wr;
  logic lane0_wr;

  assign bus_req = cyc_i && stb_i && !ack_reg;
  assign bus_wr = bus_req && we_i;
  assign lane0_wr = bus_wr && sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req;
  end

  // ==========================================================
  // event pin synchroniser and edge detect
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_s3_reg <= 1'b0;
    end
    else
    begin
      ev_s1_reg <= event_pin_i;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
    end
  end

  logic ev_edge;
  assign ev_edge = ev_s2_reg && !ev_s3_reg;

  // ==========================================================
  // count clock selection
  // dividers restart with the run enable so the first tick spacing is fixed
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg.low_run)
      sys_div_reg <= 2'h0;
    else
      sys_div_reg <= sys_div_reg + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg.low_run)
      ev_div_reg <= 3'h0;
    else if (ev_edge)
      ev_div_reg <= ev_div_reg + 3'h1;
  end

  logic tick;
  always_comb
  begin
    tick = 1'b0;
    case (ctrl_reg.clk_sel)
      CDT_SEL_SYS: tick = 1'b1; // [R9]
      CDT_SEL_SYS_DIV4: tick = (sys_div_reg == CDT_SYS_DIV4_LAST); // [R9]
      CDT_SEL_EXT: tick = ev_edge; // [R1] [R9]
      CDT_SEL_EXT_DIV2: tick = ev_edge && ev_div_reg[0]; // [R9]
      CDT_SEL_EXT_DIV4: tick = ev_edge && (&ev_div_reg[1:0]); // [R9]
      CDT_SEL_EXT_DIV8: tick = ev_edge && (&ev_div_reg); // [R9]
      default: tick = 1'b0; // [R17]
    endcase
    tick = tick && ctrl_reg.low_run;
  end

  // ==========================================================
  // compare logic
  logic low_match;
  logic high_match;
  logic match_evt;

  assign low_match = (low_counter_reg == low_compare_reg);
  assign high_match = (high_counter_reg == high_compare_reg);
  // in cascade a lone low match is ignored [R12] [R13]
  assign match_evt = tick && low_match && (!ctrl_reg.cascade || high_match);

  // ==========================================================
  // counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg.low_run) // [R18] [R11]
      low_counter_reg <= CDT_CNT_RST;
    else if (match_evt) // [R2] [R4] [R12]
      low_counter_reg <= CDT_CNT_RST;
    else if (tick) // [R1] [R10] [R14]
      low_counter_reg <= low_counter_reg + 8'h01;
  end

  // high half only lives in cascade; its own enable is not consulted
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg.low_run || !ctrl_reg.cascade) // [R11] [R18]
      high_counter_reg <= CDT_CNT_RST;
    else if (match_evt) // [R12]
      high_counter_reg <= CDT_CNT_RST;
    else if (tick && (&low_counter_reg)) // [R10]
      high_counter_reg <= high_counter_reg + 8'h01;
  end

  // ==========================================================
  // square wave
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg.low_run || !ctrl_reg.toe) // [R5] [R6]
      tog_reg <= 1'b0;
    else if (match_evt && !ctrl_reg.cascade) // [R4] [R7]
      tog_reg <= !tog_reg;
  end

  // pin shows the port latch unless the timer owns it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      toggle_pin_o <= 1'b0;
      toggle_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      toggle_pin_o <= ctrl_reg.toe ? tog_reg : port_reg.out_latch;
      toggle_pin_oe_n_o <= port_reg.output_line_direction;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CDT_CTRL_RST;
    else if (lane0_wr && adr_i == CDT_CTRL_OFS)
      ctrl_reg <= dat_i[$bits(cdt_ctrl_t)-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_reg <= CDT_PORT_RST;
    else if (lane0_wr && adr_i == CDT_PORT_OFS)
      port_reg <= dat_i[$bits(cdt_port_t)-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_compare_reg <= CDT_CMP_RST;
      high_compare_reg <= CDT_CMP_RST;
    end
    else if (lane0_wr)
    begin
      if (adr_i == CDT_LOW_CMP_OFS)
        low_compare_reg <= dat_i[7:0];
      if (adr_i == CDT_HIGH_CMP_OFS)
        high_compare_reg <= dat_i[7:0];
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  logic stat_clr;
  assign stat_clr = lane0_wr && adr_i == CDT_IRQ_STAT_OFS && dat_i[CDT_IRQ_LOW_MATCH_POS];

  // a match in the clearing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= 1'b0;
    else
      irq_stat_reg <= (irq_stat_reg && !stat_clr) || match_evt; // [R2] [R4] [R12]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= 1'b0;
    else if (lane0_wr && adr_i == CDT_IRQ_MASK_OFS)
      irq_mask_reg <= dat_i[CDT_IRQ_LOW_MATCH_POS];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_stat_reg && irq_mask_reg;
  end

  // ==========================================================
  // read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_reg <= 32'h0000_0000;
    else if (bus_req && !we_i)
    begin
      dat_reg <= 32'h0000_0000;
      case (adr_i)
        CDT_CTRL_OFS: dat_reg[$bits(cdt_ctrl_t)-1:0] <= ctrl_reg;
        CDT_LOW_CMP_OFS: dat_reg[7:0] <= low_compare_reg;
        CDT_HIGH_CMP_OFS: dat_reg[7:0] <= high_compare_reg;
        CDT_COUNT_OFS:
        begin
          dat_reg[7:0] <= low_counter_reg;
          dat_reg[CDT_COUNT_HIGH_POS+:8] <= high_counter_reg;
          dat_reg[CDT_COUNT_TOG_POS] <= tog_reg;
        end
        CDT_IRQ_STAT_OFS: dat_reg[CDT_IRQ_LOW_MATCH_POS] <= irq_stat_reg;
        CDT_IRQ_MASK_OFS: dat_reg[CDT_IRQ_LOW_MATCH_POS] <= irq_mask_reg;
        CDT_PORT_OFS: dat_reg[$bits(cdt_port_t)-1:0] <= port_reg;
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet3;
    !tick [*3];
  endsequence

  property p_r1_event_count;
    ctrl_reg.clk_sel == CDT_SEL_EXT && tick && !match_evt
      |=> low_counter_reg == 8'($past(low_counter_reg) + 8'h01);
  endproperty
  a_r1_event_count: assert property (p_r1_event_count) // [R1]
    else $error("event edge did not advance low counter");

  property p_r2_match_clear;
    tick && !ctrl_reg.cascade && low_match |=> low_counter_reg == 8'h00 && irq_stat_reg;
  endproperty
  a_r2_match_clear: assert property (p_r2_match_clear) // [R2]
    else $error("8-bit match did not clear counter and flag interrupt");

  property p_r4_toggle;
    tick && !ctrl_reg.cascade && low_match && ctrl_reg.toe |=> tog_reg != $past(tog_reg);
  endproperty
  a_r4_toggle: assert property (p_r4_toggle) // [R4]
    else $error("match did not invert square wave");

  property p_r5_stop_low;
    !ctrl_reg.low_run |=> !tog_reg and (ctrl_reg.toe |=> !toggle_pin_o);
  endproperty
  a_r5_stop_low: assert property (p_r5_stop_low) // [R5]
    else $error("square wave not forced low while stopped");

  property p_r6_start_low;
    $rose(ctrl_reg.toe) |-> !tog_reg;
  endproperty
  a_r6_start_low: assert property (p_r6_start_low) // [R6]
    else $error("toggle output not low when enabled");

  property p_r9_div4;
    ctrl_reg.low_run && ctrl_reg.clk_sel == CDT_SEL_SYS_DIV4 && tick
      ##1 ctrl_reg.clk_sel == CDT_SEL_SYS_DIV4 |-> s_quiet3;
  endproperty
  a_r9_div4: assert property (p_r9_div4) // [R9]
    else $error("divide-by-four tick came early");

  property p_r10_carry;
    ctrl_reg.cascade && tick && low_counter_reg == 8'hff && !match_evt
      |=> high_counter_reg == 8'($past(high_counter_reg) + 8'h01) && low_counter_reg == 8'h00;
  endproperty
  a_r10_carry: assert property (p_r10_carry) // [R10]
    else $error("low wrap did not carry into high counter");

  property p_r11_low_only;
    ctrl_reg.cascade && !ctrl_reg.low_run |=> high_counter_reg == 8'h00;
  endproperty
  a_r11_low_only: assert property (p_r11_low_only) // [R11]
    else $error("high counter moved without low run enable");

  property p_r12_both_clear;
    ctrl_reg.cascade && tick && low_match && high_match
      |=> low_counter_reg == 8'h00 && high_counter_reg == 8'h00 && irq_stat_reg;
  endproperty
  a_r12_both_clear: assert property (p_r12_both_clear) // [R12]
    else $error("double match did not clear both counters");

  property p_r13_lone_match;
    ctrl_reg.cascade && tick && low_match && !high_match
      |-> !match_evt ##1 low_counter_reg == 8'($past(low_counter_reg) + 8'h01);
  endproperty
  a_r13_lone_match: assert property (p_r13_lone_match) // [R13]
    else $error("lone low match acted in cascade");

  property p_r17_no_clock;
    ctrl_reg.clk_sel[2:1] == 2'b11 |-> !tick;
  endproperty
  a_r17_no_clock: assert property (p_r17_no_clock) // [R17]
    else $error("undefined select produced a count tick");

  property p_r18_hold_zero;
    !ctrl_reg.low_run |=> low_counter_reg == 8'h00;
  endproperty
  a_r18_hold_zero: assert property (p_r18_hold_zero) // [R18]
    else $error("stopped low counter not held at zero");

endmodule : cdt_timer

`default_nettype wire

// File: verification/cdt_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// event pulse source and pulled-up square-wave line
module cdt_pin_model
(
  input wire logic clk_i,
  input wire logic toggle_pin_i,
  input wire logic toggle_pin_oe_n_i,
  output logic event_pin_o,
  output logic line_o
);
  // undriven line floats high, so a missing drive never reads as low
  assign line_o = toggle_pin_oe_n_i ? 1'b1 : toggle_pin_i;

  initial event_pin_o = 1'b0;

  // w cycles high then w low per pulse: small w is a prompt source, large w a slow one
  task automatic send(input int n, input int w);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      event_pin_o <= 1'b1;
      repeat (w) @(posedge clk_i);
      event_pin_o <= 1'b0;
      repeat (w - 1) @(posedge clk_i);
    end
  endtask : send
endmodule : cdt_pin_model

`default_nettype wire

// File: verification/cascaded_dual_8bit_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module cascaded_dual_8bit_timer_tb
  import cdt_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, irq, tog, tog_oe_n, evt, line;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int t0, t1, t2;
  logic [2:0] codes [6] = '{CDT_SEL_EXT, CDT_SEL_EXT_DIV2, CDT_SEL_EXT_DIV4,
    CDT_SEL_EXT_DIV8, 3'h6, 3'h7};
  logic [31:0] exp_cnt [6] = '{32'h8, 32'h4, 32'h2, 32'h1, 32'h0, 32'h0};

  cdt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .event_pin_i(evt), .toggle_pin_o(tog), .toggle_pin_oe_n_o(tog_oe_n), .irq_o(irq));

  cdt_pin_model src (.clk_i(clk_i), .toggle_pin_i(tog), .toggle_pin_oe_n_i(tog_oe_n),
    .event_pin_o(evt), .line_o(line));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // verdict and hang guard
  task automatic close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================
  // bus cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  function automatic logic [31:0] ctl(input logic [2:0] s, input logic c, input logic t);
    cdt_ctrl_t v;
    v = '{clk_sel: s, cascade: c, toe: t, high_run: 1'b0, low_run: 1'b0};
    return {25'h0, v};
  endfunction : ctl

  // stop, select, load compares, start low run only
  task automatic cfg(input logic [31:0] c, input logic [7:0] lc, input logic [7:0] hc);
    wb(1'b1, CDT_CTRL_OFS, 32'h0);
    wb(1'b1, CDT_CTRL_OFS, c);
    wb(1'b1, CDT_LOW_CMP_OFS, {24'h0, lc});
    wb(1'b1, CDT_HIGH_CMP_OFS, {24'h0, hc});
    wb(1'b1, CDT_CTRL_OFS, c | 32'h1);
  endtask : cfg

  // sampled at edges only, so differences are exact cycle counts
  task automatic wait_lvl(input bit w, input logic lv, output int t);
    do @(posedge clk_i); while ((w ? line : irq) !== lv);
    t = cycles;
  endtask : wait_lvl

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CDT_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, CDT_PORT_OFS, 32'h0);
    chk(q, 32'h3);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, line}, 32'h1);
    // ==========================================================
    // 8-bit interval, interrupt mask and clear
    wb(1'b1, CDT_IRQ_MASK_OFS, 32'h1);
    cfg(ctl(CDT_SEL_SYS, 1'b0, 1'b0), 8'h14, 8'h00);
    wait_lvl(0, 1'b1, t0);
    wb(1'b1, CDT_IRQ_STAT_OFS, 32'h1);
    wait_lvl(0, 1'b0, t1);
    wait_lvl(0, 1'b1, t1);
    chk(32'(t1 - t0), 32'h15);
    wb(1'b1, CDT_IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, CDT_CTRL_OFS, 32'h0);
    wb(1'b0, CDT_COUNT_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, CDT_IRQ_STAT_OFS, 32'h1);
    wb(1'b0, CDT_IRQ_STAT_OFS, 32'h0);
    chk(q, 32'h0);
    // ==========================================================
    // square wave on system clock and its quarter
    wb(1'b1, CDT_PORT_OFS, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      cfg(ctl(i ? CDT_SEL_SYS_DIV4 : CDT_SEL_SYS, 1'b0, 1'b1), i ? 8'h01 : 8'h03, 8'h00);
      chk({31'h0, line}, 32'h0);
      wait_lvl(1, 1'b1, t0);
      wait_lvl(1, 1'b0, t1);
      wait_lvl(1, 1'b1, t2);
      chk(32'(t1 - t0), i ? 32'h8 : 32'h4);
      chk(32'(t2 - t0), i ? 32'h10 : 32'h8);
      wb(1'b1, CDT_CTRL_OFS, ctl(CDT_SEL_SYS_DIV4, 1'b0, 1'b1));
      repeat (10) @(posedge clk_i);
      chk({31'h0, line}, 32'h0);
    end
    // ==========================================================
    // event counting through each divider
    wb(1'b1, CDT_CTRL_OFS, 32'h0);
    // timer not owning the pin: the port latch shows through
    wb(1'b1, CDT_PORT_OFS, 32'h4);
    repeat (2) @(posedge clk_i);
    chk({31'h0, line}, 32'h1);
    wb(1'b1, CDT_PORT_OFS, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      cfg(ctl(codes[i], 1'b0, 1'b0), 8'hff, 8'h00);
      src.send(8, 2);
      repeat (5) @(posedge clk_i);
      wb(1'b0, CDT_COUNT_OFS, 32'h0);
      chk(q, exp_cnt[i]);
    end
    cfg(ctl(CDT_SEL_EXT, 1'b0, 1'b0), 8'h02, 8'h00);
    wb(1'b1, CDT_IRQ_STAT_OFS, 32'h1);
    src.send(3, 5);
    repeat (5) @(posedge clk_i);
    wb(1'b0, CDT_COUNT_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, CDT_IRQ_STAT_OFS, 32'h0);
    chk(q, 32'h1);
    // ==========================================================
    // cascaded 16-bit interval
    wb(1'b1, CDT_IRQ_MASK_OFS, 32'h1);
    cfg(ctl(CDT_SEL_SYS, 1'b1, 1'b0), 8'h02, 8'h01);
    wb(1'b1, CDT_IRQ_STAT_OFS, 32'h1);
    repeat (10) @(posedge clk_i);
    wb(1'b0, CDT_IRQ_STAT_OFS, 32'h0);
    chk(q, 32'h0);
    wait_lvl(0, 1'b1, t0);
    wb(1'b1, CDT_IRQ_STAT_OFS, 32'h1);
    wait_lvl(0, 1'b0, t1);
    wait_lvl(0, 1'b1, t1);
    chk(32'(t1 - t0), 32'h103);
    wb(1'b0, CDT_IRQ_STAT_OFS, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, CDT_CTRL_OFS, ctl(CDT_SEL_SYS, 1'b1, 1'b0) | 32'h2);
    repeat (5) @(posedge clk_i);
    wb(1'b0, CDT_COUNT_OFS, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule : cascaded_dual_8bit_timer_tb

`default_nettype wire
